// >>> epr_pkg.sv
package epr_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_RES     = 8'h04;
  localparam logic [7:0] OFS_PRESET  = 8'h08;
  localparam logic [7:0] OFS_LIMMIN  = 8'h0c;
  localparam logic [7:0] OFS_LIMMAX  = 8'h10;
  localparam logic [7:0] OFS_CYCLE   = 8'h14;
  localparam logic [7:0] OFS_SYNCCNT = 8'h18;
  localparam logic [7:0] OFS_STATUS  = 8'h1c;
  localparam logic [7:0] OFS_MASK    = 8'h20;
  localparam logic [7:0] OFS_POS     = 8'h24;
  localparam logic [7:0] OFS_CAMSTAT = 8'h28;
  localparam logic [1:0] CAM_PAGE    = 2'h1;

  // control field positions
  localparam int CTRL_POLLED = 0;
  localparam int CTRL_CYCLIC = 1;
  localparam int CTRL_SYNC   = 2;
  localparam int CTRL_DIR    = 3;

  // status / mask bit positions
  localparam int ST_TX     = 0;
  localparam int ST_RTR    = 1;
  localparam int ST_SYNC   = 2;
  localparam int ST_ERRCTL = 3;
  localparam int ST_BUSOFF = 4;
  localparam int ST_LIMIT  = 5;
  localparam int ST_CAM    = 6;
  localparam int ST_W      = 7;

  // flag bit of the process value
  localparam int LIMIT_BIT = 31;

  // reset values
  localparam logic [3:0]  CTRL_RST    = 4'h1;
  localparam logic [16:0] RES_RST     = 17'h10000;
  localparam logic [30:0] LIMMIN_RST  = 31'h00000000;
  localparam logic [30:0] LIMMAX_RST  = 31'h7fffffff;
  localparam logic [15:0] CYCLE_RST   = 16'h0063;
  localparam logic [7:0]  SYNCCNT_RST = 8'h01;

  // network states
  localparam logic [1:0] NET_PREOP = 2'h0;
  localparam logic [1:0] NET_STOP  = 2'h1;
  localparam logic [1:0] NET_OPER  = 2'h2;

  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LED_UNIT_MS   = 50;
  localparam logic [5:0] LED_UNIT_LAST = 6'(LED_UNIT_MS - 1);

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    RED_OFF     = 5'h01,
    RED_FLICKER = 5'h02,
    RED_SINGLE  = 5'h04,
    RED_DOUBLE  = 5'h08,
    RED_ON      = 5'h10
  } epr_red_t;

endpackage

// >>> epr_position_reporting.sv
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns
// Summary of operation
// - green LED blinks pre-operational, single flash stopped, on operational
// - red LED flickers while bit-rate search is active
// - red single flash when an error counter reaches warning level
// - red double flash after node-guarding or heartbeat event
// - red on while bus-off, off when no error
// - remote request samples processed position and replies
// - cyclic mode sends position every 1 to 65536 ms
// - sync mode sends current position after every Nth sync telegram
// - no delay or offset time between sync and reply
// - sync counter sends only on every Nth sync seen, then counts again from zero
// - direction setting reverses the counting sense of the code
// - single turn scaled to programmed steps per revolution
// - preset write sets offset so position equals preset now
// - two limits; flag bit set when position outside their range
// - eight programmable cam windows over full range
module epr_position_reporting #(
  parameter int MS_CYCLES = epr_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // angle sensor
  input  wire logic [15:0] rawAngle,
  input  wire logic [14:0] rawTurns,
  // network controller
  input  wire logic [1:0]  netState,
  input  wire logic        bitRateSearch,
  input  wire logic        errWarn,
  input  wire logic        busOff,
  input  wire logic        errCtrlEvent,
  input  wire logic        rtrReq,
  input  wire logic        syncRx,
  // position telegram
  output logic             txValid,
  output logic [31:0]      txData,
  // indicators and interrupt
  output logic             ledGreen,
  output logic             ledRed,
  output logic             irq,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // reset release
  logic [1:0]  rstSync_reg;
  wire         rstI = rstSync_reg[1];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rstSync_reg <= 2'h0;
    else rstSync_reg <= {rstSync_reg[0], 1'b1};
  end

  // configuration
  logic [3:0]  ctrl_reg;
  logic [16:0] res_reg;
  logic [30:0] offset_reg;
  logic [30:0] limMin_reg;
  logic [30:0] limMax_reg;
  logic [15:0] cycle_reg;
  logic [7:0]  syncCnt_reg;
  logic [6:0]  status_reg;
  logic [6:0]  mask_reg;
  logic [30:0] camLo_reg [8];
  logic [30:0] camHi_reg [8];

  // position processing
  wire  [32:0] angleScaled = 33'(rawAngle) * 33'(res_reg);
  wire  [31:0] turnsScaled = 32'(rawTurns) * 32'(res_reg);
  wire  [30:0] basePos = 31'(turnsScaled + 32'(angleScaled[32:16]));
  wire  [31:0] spanTop = 32'(res_reg) * 32'h00008000;
  wire  [30:0] rangeMax = 31'(spanTop - 32'h1);
  wire  [30:0] dirPos = ctrl_reg[epr_pkg::CTRL_DIR] ?
                        31'(rangeMax - basePos) : basePos;
  wire  [30:0] curPos = 31'(dirPos + offset_reg);
  wire         outside = (curPos < limMin_reg) || (curPos > limMax_reg);
  wire  [31:0] procVal = {outside, curPos};

  // cam windows
  wire  [7:0]  camHit;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_cam
      assign camHit[gi] = (curPos >= camLo_reg[gi]) &&
                          (curPos <= camHi_reg[gi]);
    end
  endgenerate

  logic [7:0]  camState_reg;
  logic        outside_reg;
  logic [30:0] pos_reg;

  // millisecond base
  logic [16:0] msCnt_reg;
  wire         msTick = (msCnt_reg == 17'(MS_CYCLES - 1));
  logic [15:0] cycCnt_reg;
  wire         cycDue = msTick && (cycCnt_reg == cycle_reg);

  // transmit triggers
  wire         oper = (netState == epr_pkg::NET_OPER);
  wire         pollGo = rtrReq && ctrl_reg[epr_pkg::CTRL_POLLED];
  wire         cycGo = cycDue && ctrl_reg[epr_pkg::CTRL_CYCLIC];
  logic [7:0]  syncSeen_reg;
  wire  [7:0]  syncNeed = (syncCnt_reg == 8'h0) ? 8'h1 : syncCnt_reg;
  wire         syncReach = (8'(syncSeen_reg + 8'h1) >= syncNeed);
  wire         syncGo = syncRx && ctrl_reg[epr_pkg::CTRL_SYNC] &&
                        syncReach;
  wire         txGo = oper && (pollGo || cycGo || syncGo);

  // bus decode
  logic        awHeld_reg;
  logic        wHeld_reg;
  logic [7:0]  awAddr_reg;
  logic [31:0] wData_reg;
  wire         awTake = s_axi_awvalid && s_axi_awready;
  wire         wTake = s_axi_wvalid && s_axi_wready;
  wire         awHave = awHeld_reg || awTake;
  wire         wHave = wHeld_reg || wTake;
  wire  [7:0]  wAddr = awHeld_reg ? awAddr_reg : s_axi_awaddr;
  wire  [31:0] wVal = wHeld_reg ? wData_reg : s_axi_wdata;
  wire         doWrite = awHave && wHave && !s_axi_bvalid;
  wire         wFull = (s_axi_wstrb == 4'hf);
  wire         wCam = (wAddr[7:6] == epr_pkg::CAM_PAGE);
  wire  [2:0]  wCamIdx = wAddr[5:3];
  wire         arTake = s_axi_arvalid && s_axi_arready;
  wire         rdStatus = arTake && (s_axi_araddr == epr_pkg::OFS_STATUS);

  function automatic logic isWritable(input logic [7:0] a);
    isWritable = (a[7:6] == epr_pkg::CAM_PAGE) && (a[1:0] == 2'h0) ||
                 (a <= epr_pkg::OFS_MASK) && (a != epr_pkg::OFS_STATUS) &&
                 (a[1:0] == 2'h0);
  endfunction

  function automatic logic [32:0] readMux(input logic [7:0] a);
    readMux = {1'b1, 32'h0};
    if (a[7:6] == epr_pkg::CAM_PAGE && a[1:0] == 2'h0) begin
      readMux = {1'b0, 1'b0, a[2] ? camHi_reg[a[5:3]] : camLo_reg[a[5:3]]};
    end else begin
      case (a)
        epr_pkg::OFS_CTRL:    readMux = {1'b0, 28'h0, ctrl_reg};
        epr_pkg::OFS_RES:     readMux = {1'b0, 15'h0, res_reg};
        epr_pkg::OFS_PRESET:  readMux = {1'b0, 1'b0, pos_reg};
        epr_pkg::OFS_LIMMIN:  readMux = {1'b0, 1'b0, limMin_reg};
        epr_pkg::OFS_LIMMAX:  readMux = {1'b0, 1'b0, limMax_reg};
        epr_pkg::OFS_CYCLE:   readMux = {1'b0, 16'h0, cycle_reg};
        epr_pkg::OFS_SYNCCNT: readMux = {1'b0, 24'h0, syncCnt_reg};
        epr_pkg::OFS_STATUS:  readMux = {1'b0, 25'h0, status_reg};
        epr_pkg::OFS_MASK:    readMux = {1'b0, 25'h0, mask_reg};
        epr_pkg::OFS_POS:     readMux = {1'b0, outside_reg, pos_reg};
        epr_pkg::OFS_CAMSTAT: readMux = {1'b0, 24'h0, camState_reg};
        default:              readMux = {1'b1, 32'h0};
      endcase
    end
  endfunction

  wire  [32:0] rdWord = readMux(s_axi_araddr);
  wire         wOk = isWritable(wAddr) && wFull;
  wire         wr = doWrite && wOk;

  // event sources
  logic        busOffPrev_reg;
  wire  [6:0]  evSet;
  assign evSet[epr_pkg::ST_TX]     = txGo;
  assign evSet[epr_pkg::ST_RTR]    = rtrReq;
  assign evSet[epr_pkg::ST_SYNC]   = syncRx;
  assign evSet[epr_pkg::ST_ERRCTL] = errCtrlEvent;
  assign evSet[epr_pkg::ST_BUSOFF] = busOff && !busOffPrev_reg;
  assign evSet[epr_pkg::ST_LIMIT]  = procVal[epr_pkg::LIMIT_BIT] &&
                                     !outside_reg;
  assign evSet[epr_pkg::ST_CAM]    = (camHit != camState_reg);
  wire  [6:0]  statusNext = (rdStatus ? 7'h0 : status_reg) | evSet;

  // bus handshake
  always_ff @(posedge clk or negedge rstI) begin
    if (!rstI) begin
      awHeld_reg    <= 1'b0;
      wHeld_reg     <= 1'b0;
      awAddr_reg    <= 8'h0;
      wData_reg     <= 32'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= epr_pkg::RESP_OKAY;
    end else begin
      if (awTake) awAddr_reg <= s_axi_awaddr;
      if (wTake) wData_reg <= s_axi_wdata;
      awHeld_reg    <= awHave && !doWrite;
      wHeld_reg     <= wHave && !doWrite;
      s_axi_awready <= !(awHave && !doWrite) && !s_axi_awready;
      s_axi_wready  <= !(wHave && !doWrite) && !s_axi_wready;
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wOk ? epr_pkg::RESP_OKAY : epr_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstI) begin
    if (!rstI) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= epr_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !arTake;
      if (arTake) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdWord[31:0];
        s_axi_rresp  <= rdWord[32] ? epr_pkg::RESP_SLVERR :
                                     epr_pkg::RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // register writes
  always_ff @(posedge clk or negedge rstI) begin
    if (!rstI) begin
      ctrl_reg    <= epr_pkg::CTRL_RST;
      res_reg     <= epr_pkg::RES_RST;
      offset_reg  <= 31'h0;
      limMin_reg  <= epr_pkg::LIMMIN_RST;
      limMax_reg  <= epr_pkg::LIMMAX_RST;
      cycle_reg   <= epr_pkg::CYCLE_RST;
      syncCnt_reg <= epr_pkg::SYNCCNT_RST;
      mask_reg    <= 7'h0;
    end else if (wr && !wCam) begin
      case (wAddr)
        epr_pkg::OFS_CTRL:    ctrl_reg    <= wVal[3:0];
        epr_pkg::OFS_RES:     res_reg     <= wVal[16:0];
        epr_pkg::OFS_PRESET:  offset_reg  <= 31'(wVal[30:0] - dirPos);
        epr_pkg::OFS_LIMMIN:  limMin_reg  <= wVal[30:0];
        epr_pkg::OFS_LIMMAX:  limMax_reg  <= wVal[30:0];
        epr_pkg::OFS_CYCLE:   cycle_reg   <= wVal[15:0];
        epr_pkg::OFS_SYNCCNT: syncCnt_reg <= wVal[7:0];
        epr_pkg::OFS_MASK:    mask_reg    <= wVal[6:0];
        default:              mask_reg    <= mask_reg;
      endcase
    end
  end

  // cam window storage
  generate
    for (gi = 0; gi < 8; gi++) begin : g_camreg
      always_ff @(posedge clk or negedge rstI) begin
        if (!rstI) begin
          camLo_reg[gi] <= 31'h0;
          camHi_reg[gi] <= 31'h0;
        end else if (wr && wCam && wCamIdx == 3'(gi)) begin
          if (wAddr[2]) camHi_reg[gi] <= wVal[30:0];
          else camLo_reg[gi] <= wVal[30:0];
        end
      end
    end
  endgenerate

  // status and interrupt
  always_ff @(posedge clk or negedge rstI) begin
    if (!rstI) begin
      status_reg     <= 7'h0;
      busOffPrev_reg <= 1'b0;
      irq            <= 1'b0;
    end else begin
      status_reg     <= statusNext;
      busOffPrev_reg <= busOff;
      irq            <= |(statusNext & mask_reg);
    end
  end

  // process value snapshot
  always_ff @(posedge clk or negedge rstI) begin
    if (!rstI) begin
      pos_reg      <= 31'h0;
      outside_reg  <= 1'b0;
      camState_reg <= 8'h0;
      txValid      <= 1'b0;
      txData       <= 32'h0;
    end else begin
      pos_reg      <= curPos;
      outside_reg  <= procVal[epr_pkg::LIMIT_BIT];
      camState_reg <= camHit;
      txValid      <= txGo;
      if (txGo) txData <= procVal;
    end
  end

  // cycle and sync counters
  always_ff @(posedge clk or negedge rstI) begin
    if (!rstI) begin
      msCnt_reg    <= 17'h0;
      cycCnt_reg   <= 16'h0;
      syncSeen_reg <= 8'h0;
    end else begin
      msCnt_reg <= msTick ? 17'h0 : 17'(msCnt_reg + 17'h1);
      if (!ctrl_reg[epr_pkg::CTRL_CYCLIC] || cycDue) cycCnt_reg <= 16'h0;
      else if (msTick) cycCnt_reg <= 16'(cycCnt_reg + 16'h1);
      if (!ctrl_reg[epr_pkg::CTRL_SYNC]) syncSeen_reg <= 8'h0;
      else if (syncRx) syncSeen_reg <= syncReach ? 8'h0 :
                                       8'(syncSeen_reg + 8'h1);
    end
  end

  // indicator timing in 50 ms units
  logic [5:0]  unitCnt_reg;
  logic [4:0]  phase_reg;
  logic        flick_reg;
  wire         unitTick = msTick && (unitCnt_reg == epr_pkg::LED_UNIT_LAST);

  always_ff @(posedge clk or negedge rstI) begin
    if (!rstI) begin
      unitCnt_reg <= 6'h0;
      phase_reg   <= 5'h0;
      flick_reg   <= 1'b0;
    end else begin
      if (unitTick) unitCnt_reg <= 6'h0;
      else if (msTick) unitCnt_reg <= 6'(unitCnt_reg + 6'h1);
      if (unitTick) phase_reg <= 5'(phase_reg + 5'h1);
      if (unitTick) flick_reg <= !flick_reg;
    end
  end

  wire         flashOne = (phase_reg[4:2] == 3'h0);
  wire         flashTwo = flashOne || (phase_reg[4:2] == 3'h2);
  wire         blink = phase_reg[2];

  epr_pkg::epr_red_t redMode;
  assign redMode = busOff ? epr_pkg::RED_ON :
                   status_reg[epr_pkg::ST_ERRCTL] ? epr_pkg::RED_DOUBLE :
                   errWarn ? epr_pkg::RED_SINGLE :
                   bitRateSearch ? epr_pkg::RED_FLICKER :
                   epr_pkg::RED_OFF;

  logic        redNext;
  always_comb begin
    case (redMode)
      epr_pkg::RED_ON:      redNext = 1'b1;
      epr_pkg::RED_DOUBLE:  redNext = flashTwo;
      epr_pkg::RED_SINGLE:  redNext = flashOne;
      epr_pkg::RED_FLICKER: redNext = flick_reg;
      default:              redNext = 1'b0;
    endcase
  end

  wire         greenNext = (netState == epr_pkg::NET_OPER) ? 1'b1 :
                           (netState == epr_pkg::NET_STOP) ? flashOne :
                           (netState == epr_pkg::NET_PREOP) ? blink :
                           1'b0;

  always_ff @(posedge clk or negedge rstI) begin
    if (!rstI) begin
      ledGreen <= 1'b0;
      ledRed   <= 1'b0;
    end else begin
      ledGreen <= greenNext;
      ledRed   <= redNext;
    end
  end

endmodule // epr_position_reporting

// >>> epr_position_reporting_chk.sv
`timescale 1ns/1ns
module epr_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // network side
  input wire logic [1:0]  netState,
  input wire logic        busOff,
  input wire logic        txValid,
  input wire logic [31:0] txData,
  input wire logic        ledGreen,
  input wire logic        ledRed,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  logic [2:0] upCnt;
  wire        up = upCnt == 3'h7;

  // settle time after reset release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      upCnt <= 3'h0;
    else if (!up)
      upCnt <= upCnt + 3'h1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  a_tx_oper: assert property (txValid |-> $past(netState) == 2'h2)
    else $error("telegram outside operational state");
  a_tx_hold: assert property (up && !txValid |-> $stable(txData))
    else $error("telegram data moved without a send");
  a_red_busoff: assert property (up && busOff ##1 busOff |-> ledRed)
    else $error("red indicator dark while bus-off");
  a_green_oper: assert property (up && netState == 2'h2 ##1
    netState == 2'h2 |-> ledGreen)
    else $error("green indicator dark while operational");
  a_green_off: assert property (up && netState == 2'h3 ##1
    netState == 2'h3 |-> !ledGreen)
    else $error("green indicator lit without a state");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_w_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");

  c_tx: cover property (txValid);
  c_busoff: cover property (up && busOff ##1 ledRed);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule // epr_chk

bind epr_position_reporting epr_chk chk_u (.clk, .rstn, .netState, .busOff,
  .txValid, .txData, .ledGreen, .ledRed, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// >>> epr_host_model.sv
`timescale 1ns/1ns
module epr_host_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // bench command: 1 remote request, 2 sync
  input  wire logic [1:0]  hostCmd,
  // network side of the block
  output logic             rtrReq,
  output logic             syncRx,
  input  wire logic        txValid,
  input  wire logic [31:0] txData,
  // received telegrams
  output int               rxCount,
  output logic [31:0]      rxLast
);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rtrReq  <= 1'b0;
      syncRx  <= 1'b0;
      rxCount <= 0;
      rxLast  <= 32'h0;
    end else begin
      rtrReq <= hostCmd == 2'h1;
      syncRx <= hostCmd == 2'h2;
      if (txValid) begin
        rxCount <= rxCount + 1;
        rxLast  <= txData;
      end
    end
  end
endmodule // epr_host_model

// >>> test_encoder_position_reporting.sv
`timescale 1ns/1ns
module test_encoder_position_reporting;
  localparam int MS = 10;
  logic        clk, rstn, rtrReq, syncRx, txValid, ledGreen, ledRed, irq;
  logic        bitRateSearch, errWarn, busOff, errCtrlEvent, dir;
  logic [15:0] rawAngle, seed;
  logic [14:0] rawTurns;
  logic [1:0]  netState, hostCmd, s_axi_bresp, s_axi_rresp, r;
  logic [31:0] txData, rxLast, s_axi_wdata, s_axi_rdata, d, t;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          errors, tests_run, rxCount, i, gc, rc;
  longint      res, offs, lmin, lmax;
  logic [39:0] rstTab [7] = '{40'h0000000001, 40'h0400010000,
    40'h0c00000000, 40'h107fffffff, 40'h1400000063, 40'h1800000001,
    40'h2000000000};

  epr_position_reporting #(.MS_CYCLES(MS)) dut_u (.clk, .rstn, .rawAngle,
    .rawTurns, .netState, .bitRateSearch, .errWarn, .busOff, .errCtrlEvent,
    .rtrReq, .syncRx, .txValid, .txData, .ledGreen, .ledRed, .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  epr_host_model host_u (.clk, .rstn, .hostCmd, .rtrReq, .syncRx, .txValid,
    .txData, .rxCount, .rxLast);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // processed position as the host should see it
  function automatic logic [31:0] expPos();
    longint p;
    p = longint'(rawTurns) * res + ((longint'(rawAngle) * res) >> 16);
    if (dir)
      p = res * 32768 - 1 - p;
    p = (p + offs) & 64'h7fffffff;
    return {p < lmin || p > lmax, p[30:0]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    if (s_axi_bvalid !== 1'b1) begin
      errors++;
      give_verdict();
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    if (s_axi_rvalid !== 1'b1) begin
      errors++;
      give_verdict();
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // one host request; e is the number of telegrams expected back
  task automatic trig(input logic [1:0] k, input int e);
    int c0;
    c0 = rxCount;
    @(posedge clk);
    hostCmd <= k;
    @(posedge clk);
    hostCmd <= 2'h0;
    repeat (3) @(posedge clk);
    chk(32'(rxCount - c0), 32'(e));
    if (e != 0)
      chk(rxLast, expPos());
  endtask

  // lit time of both indicators over one 32-unit pattern
  task automatic led(input int eg, input int er);
    gc = 0;
    rc = 0;
    repeat (8) @(posedge clk);
    repeat (32 * 50 * MS) begin
      @(posedge clk);
      gc += int'(ledGreen);
      rc += int'(ledRed);
    end
    chk(32'(gc), 32'(eg * 50 * MS));
    chk(32'(rc), 32'(er * 50 * MS));
  endtask

  initial begin
    {rstn, bitRateSearch, errWarn, busOff, errCtrlEvent, dir} = '0;
    {rawAngle, rawTurns, netState, hostCmd} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    seed = 16'hc8d7;
    {errors, tests_run, offs, lmin} = '0;
    res = 65536;
    lmax = 64'h7fffffff;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (rstTab[j]) begin
      rd(rstTab[j][39:32]);
      chk(d, rstTab[j][31:0]);
    end
    rd(8'h30);
    chk({d[29:0], r}, 32'h2);
    wr(8'h24, 32'h5);
    chk(32'(r), 32'h2);
    wr(8'h14, 32'hffff);
    rd(8'h14);
    chk(d, 32'hffff);
    netState <= 2'h2;
    for (i = 0; i < 4; i++) begin
      dir = i[0];
      res = i[1] ? 1000 : 65536;
      wr(8'h00, {28'h0, dir, 3'h1});
      wr(8'h04, 32'(res));
      seed = lfsr(seed);
      rawAngle <= seed;
      seed = lfsr(seed);
      rawTurns <= seed[14:0];
      trig(2'h1, 1);
    end
    wr(8'h00, 32'h1);
    dir = 1'b0;
    wr(8'h0c, 32'h100);
    lmin = 256;
    wr(8'h10, 32'h200);
    lmax = 512;
    rawTurns <= 15'h0;
    for (i = 0; i < 2; i++) begin
      rawAngle <= i[0] ? 16'hf000 : 16'h6000;
      trig(2'h1, 1);
    end
    seed = lfsr(seed);
    t = {1'b0, seed, seed[14:0]};
    wr(8'h08, t);
    offs = 0;
    d = expPos();
    offs = (longint'(t) - longint'(d[30:0]) + 64'h80000000) & 64'h7fffffff;
    trig(2'h1, 1);
    wr(8'h00, 32'h4);
    wr(8'h18, 32'h3);
    for (i = 1; i <= 6; i++)
      trig(2'h2, int'(i % 3 == 0));
    trig(2'h1, 0);
    for (i = 0; i < 2; i++) begin
      wr(8'h14, 32'(i * 4));
      wr(8'h00, 32'h2);
      repeat (100) @(posedge clk);
      #1;
      gc = rxCount;
      repeat (3 * (i * 4 + 1) * MS) @(posedge clk);
      #1;
      chk(32'(rxCount - gc), 32'h3);
      wr(8'h00, 32'h0);
    end
    wr(8'h00, 32'h1);
    netState <= 2'h1;
    trig(2'h1, 0);
    errWarn <= 1'b1;
    led(4, 4);
    errWarn <= 1'b0;
    bitRateSearch <= 1'b1;
    netState <= 2'h0;
    led(16, 16);
    netState <= 2'h3;
    repeat (3) @(posedge clk);
    chk(32'(ledGreen), 32'h0);
    netState <= 2'h2;
    errWarn <= 1'b1;
    errCtrlEvent <= 1'b1;
    @(posedge clk);
    errCtrlEvent <= 1'b0;
    led(32, 8);
    busOff <= 1'b1;
    led(32, 32);
    {busOff, errWarn, bitRateSearch} <= 3'h0;
    rd(8'h1c);
    led(32, 0);
    wr(8'h20, 32'h1);
    trig(2'h1, 1);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    rd(8'h1c);
    chk(d, 32'h3);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0);
    wr(8'h20, 32'h0);
    trig(2'h1, 1);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    t = expPos();
    wr(8'h40, {1'b0, t[30:0]});
    wr(8'h44, {1'b0, t[30:0]});
    chk(32'(r), 32'h0);
    rd(8'h28);
    chk(d, (t[30:0] == 31'h0) ? 32'hff : 32'h1);
    rd(8'h24);
    chk(d, t);
    rd(8'h08);
    chk(d, {1'b0, t[30:0]});
    give_verdict();
  end
endmodule // test_encoder_position_reporting
